//--- data_ram_partition_regs_regs.svh
// Register offsets, field masks, reset values and status bit positions
// of the data RAM partition block.
// Assumes a byte-addressed register bus with 32-bit aligned words.
`ifndef DATA_RAM_PARTITION_REGS_REGS_SVH
`define DATA_RAM_PARTITION_REGS_REGS_SVH

// Byte offsets of the registers.
`define OFS_KERNEL_PROG_BASE 8'h00
`define OFS_USER_DATA_BASE   8'h04
`define OFS_USER_PROG_BASE   8'h08
`define OFS_RAM_SIZE         8'h0C
`define OFS_PART_STATUS      8'h10

// Only bits 15:10 of a base register hold state; all others read zero.
`define BASE_WRITE_MASK      32'h0000FC00
`define BASE_RESET           32'h00000000

// Fixed capacity of the data RAM in bytes (32 KB).
`define RAM_SIZE_DEFAULT     32'h00008000

// Bit positions in the partition status register.
`define ST_KPROG_OVER_SIZE   0
`define ST_UDATA_OVER_SIZE   1
`define ST_UPROG_OVER_SIZE   2
`define ST_UDATA_NOT_ABOVE   3
`define ST_UPROG_NOT_ABOVE   4
`define ST_WIDTH             5

`endif

//--- data_ram_partition_pkg.sv
// Types and shared arithmetic of the data RAM partition block.
// Assumes nothing beyond the register header.
package data_ram_partition_pkg;

  // Region that a data RAM offset falls into.
  typedef enum logic [2:0] {
    REGION_KERNEL_DATA,
    REGION_KERNEL_PROG,
    REGION_USER_DATA,
    REGION_USER_PROG,
    REGION_OUTSIDE
  } region_e;

  typedef logic [31:0] word_t;

  // A zero base means the region is absent, so it starts where the next one does.
  function automatic word_t effective_start(input word_t base, input word_t fallback);
    effective_start = (base != 32'h00000000) ? base : fallback;
  endfunction : effective_start

endpackage : data_ram_partition_pkg

//--- partition_base_reg.sv
// One partition base register with byte-lane writes and fixed zero bits.
// Assumes write strobes are single-cycle pulses from the bus slave.
`timescale 1ns/1ps
`default_nettype none
`include "data_ram_partition_regs_regs.svh"

module partition_base_reg
  import data_ram_partition_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Write port.
  input  wire logic        wr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] wdata_i,
  // Stored value.
  output logic      [31:0] value_o
);

  typedef struct packed {
    logic [31:0] value;
  } base_state_s;

  base_state_s st;
  base_state_s next_st;
  logic [31:0] lane_mask;

  // Lanes not selected keep their old contents; masked bits never take data.
  always_comb begin
    next_st   = st;
    lane_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    if (wr_i) begin
      next_st.value = ((st.value & ~lane_mask) | (wdata_i & lane_mask))
                      & `BASE_WRITE_MASK; // R1 R2
    end
  end

  // The register clears on every reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st.value <= `BASE_RESET; // R6
    end else begin
      st <= next_st;
    end
  end

  assign value_o = st.value;

endmodule : partition_base_reg
`default_nettype wire

//--- region_classifier.sv
// Classifies a data RAM offset against the partition boundaries.
// Assumes boundaries are ordered; a misordered set is flagged elsewhere, except user program base below kernel program base with no user data base.
`timescale 1ns/1ps
`default_nettype none

module region_classifier
  import data_ram_partition_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Query.
  input  wire logic        query_valid_i,
  input  wire logic [31:0] query_addr_i,
  // Boundaries.
  input  wire logic [31:0] kprog_start_i,
  input  wire logic [31:0] udata_start_i,
  input  wire logic [31:0] uprog_start_i,
  input  wire logic [31:0] ram_end_i,
  // Answer.
  output logic             region_valid_o,
  output var region_e      region_o
);

  typedef struct packed {
    logic    valid;
    region_e region;
  } class_state_s;

  class_state_s st;
  class_state_s next_st;

  // Four contiguous regions; beyond the RAM end an offset is outside.
  always_comb begin
    next_st       = st;
    next_st.valid = query_valid_i;
    if (query_valid_i) begin
      if (query_addr_i < kprog_start_i) begin
        next_st.region = REGION_KERNEL_DATA; // R13
      end else if (query_addr_i < udata_start_i) begin
        next_st.region = REGION_KERNEL_PROG; // R13
      end else if (query_addr_i < uprog_start_i) begin
        next_st.region = REGION_USER_DATA; // R13
      end else if (query_addr_i < ram_end_i) begin
        next_st.region = REGION_USER_PROG; // R13
      end else begin
        next_st.region = REGION_OUTSIDE;
      end
    end
  end

  // Answer is registered, one cycle after the query.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st.valid  <= 1'b0;
      st.region <= REGION_KERNEL_DATA;
    end else begin
      st <= next_st;
    end
  end

  assign region_valid_o = st.valid;
  assign region_o       = st.region;

endmodule : region_classifier
`default_nettype wire

//--- data_ram_partition_regs.sv
// Top of the data RAM partition block: Wishbone register slave, the
// three partition base registers, the size readout, boundary outputs
// and a region query port for the RAM access path.
// Assumes a classic Wishbone master on clk_i with one request at a time.
//
// Functional notes
// R1: Bits 15:10 of each partition base register are writable and bits 31:16 read zero.
// R2: Bits 9:0 of each base register read zero and ignore writes, giving 1 KB steps.
// R3: A nonzero kernel program base is where the kernel program region begins.
// R4: A nonzero user data base is where the user data region begins.
// R5: A nonzero user program base is where the user program region begins.
// R6: Every reset clears all three base registers to zero.
// R7: With all three bases zero the whole RAM is kernel data.
// R8: Software keeps each base no larger than the reported RAM size.
// R9: Software keeps a nonzero user data base above the kernel program base.
// R10: Software keeps the user program base above the user data base.
// R11: The RAM size register is 32 bits wide and read-only.
// R12: The RAM size register reports the fixed RAM capacity in bytes.
// R13: The RAM splits into kernel data, kernel program, user data and user program in order.
`timescale 1ns/1ps
`default_nettype none
`include "data_ram_partition_regs_regs.svh"

module data_ram_partition_regs
  import data_ram_partition_pkg::*;
#(
  parameter logic [31:0] RAM_SIZE = `RAM_SIZE_DEFAULT,
  parameter int          ADDR_W   = 8
) (
  // Clock and reset.
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave.
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Region query from the RAM access path.
  input  wire logic              query_valid_i,
  input  wire logic [31:0]       query_addr_i,
  output logic                   region_valid_o,
  output var region_e            region_o,
  // Partition boundaries for the access checker.
  output logic      [31:0]       kprog_start_o,
  output logic      [31:0]       udata_start_o,
  output logic      [31:0]       uprog_start_o,
  output logic      [31:0]       ram_end_o,
  output logic                   all_kernel_data_o,
  // Programming fault summary.
  output logic                   config_fault_o
);

  // Index of each base register in the small array below.
  localparam int IDX_KPROG = 0;
  localparam int IDX_UDATA = 1;
  localparam int IDX_UPROG = 2;
  localparam int NUM_BASES = 3;

  typedef struct packed {
    logic                   ack;
    logic [31:0]            rdata;
    logic [31:0]            kprog_start;
    logic [31:0]            udata_start;
    logic [31:0]            uprog_start;
    logic                   all_kernel;
    logic [`ST_WIDTH-1:0]   fault;
    logic                   fault_any;
  } top_state_s;

  top_state_s st;
  top_state_s next_st;

  // Bus decode and register file wiring.
  logic                   req;
  logic                   wr_req;
  logic                   rd_req;
  logic [NUM_BASES-1:0]   base_wr;
  logic [31:0]            base_val [NUM_BASES];
  logic [ADDR_W-1:0]      base_ofs [NUM_BASES];

  // Effective region starts before they are registered.
  logic [31:0]            eff_kprog;
  logic [31:0]            eff_udata;
  logic [31:0]            eff_uprog;
  logic [`ST_WIDTH-1:0]   fault_now;

  // Offsets are narrowed to the bus address width here for the write decode; the read decode narrows them again.
  assign base_ofs[IDX_KPROG] = ADDR_W'(`OFS_KERNEL_PROG_BASE);
  assign base_ofs[IDX_UDATA] = ADDR_W'(`OFS_USER_DATA_BASE);
  assign base_ofs[IDX_UPROG] = ADDR_W'(`OFS_USER_PROG_BASE);

  // A request is taken only while ack is low, so a master that drops stb
  // on the edge that samples ack gets one access; stb held past it starts another.
  assign req    = wb_cyc_i & wb_stb_i & ~st.ack;
  assign wr_req = req & wb_we_i;
  assign rd_req = req & ~wb_we_i;

  // Write strobes for the base registers, one per matching offset.
  always_comb begin
    for (int i = 0; i < NUM_BASES; i++) begin
      base_wr[i] = wr_req & (wb_adr_i == base_ofs[i]);
    end
  end

  // The three base registers share one implementation.
  genvar g;
  generate
    for (g = 0; g < NUM_BASES; g++) begin : gen_base
      partition_base_reg u_base (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .wr_i    (base_wr[g]),
        .sel_i   (wb_sel_i),
        .wdata_i (wb_dat_i),
        .value_o (base_val[g])
      );
    end
  endgenerate

  // Region starts are resolved from the top down: an absent region
  // collapses to zero length at the start of the one above it.
  always_comb begin
    eff_uprog = effective_start(base_val[IDX_UPROG], RAM_SIZE); // R5
    eff_udata = effective_start(base_val[IDX_UDATA], eff_uprog); // R4
    eff_kprog = effective_start(base_val[IDX_KPROG], eff_udata); // R3
  end

  // Faults are live levels so they clear as soon as software repairs
  // the values; nothing here needs a clear handshake.
  always_comb begin
    fault_now = '0;
    fault_now[`ST_KPROG_OVER_SIZE] = base_val[IDX_KPROG] > RAM_SIZE; // R8
    fault_now[`ST_UDATA_OVER_SIZE] = base_val[IDX_UDATA] > RAM_SIZE; // R8
    fault_now[`ST_UPROG_OVER_SIZE] = base_val[IDX_UPROG] > RAM_SIZE; // R8
    fault_now[`ST_UDATA_NOT_ABOVE] = (base_val[IDX_UDATA] != 32'h00000000)
                                     && (base_val[IDX_UDATA] <= base_val[IDX_KPROG]); // R9
    fault_now[`ST_UPROG_NOT_ABOVE] = (base_val[IDX_UPROG] != 32'h00000000)
                                     && (base_val[IDX_UPROG] <= base_val[IDX_UDATA]); // R10
  end

  // Next state: bus answer, registered boundaries and fault status.
  always_comb begin
    next_st     = st;
    next_st.ack = req;

    // Read data is loaded with the ack and held until the next read.
    if (rd_req) begin
      unique case (wb_adr_i)
        ADDR_W'(`OFS_KERNEL_PROG_BASE): begin
          next_st.rdata = base_val[IDX_KPROG];
        end
        ADDR_W'(`OFS_USER_DATA_BASE): begin
          next_st.rdata = base_val[IDX_UDATA];
        end
        ADDR_W'(`OFS_USER_PROG_BASE): begin
          next_st.rdata = base_val[IDX_UPROG];
        end
        ADDR_W'(`OFS_RAM_SIZE): begin
          next_st.rdata = RAM_SIZE; // R11 R12
        end
        ADDR_W'(`OFS_PART_STATUS): begin
          next_st.rdata = {{(32-`ST_WIDTH){1'b0}}, st.fault};
        end
        default: begin
          // Unmapped offsets still answer, with zero data.
          next_st.rdata = 32'h00000000;
        end
      endcase
    end

    // Writes to the size and status offsets fall through with no effect.
    next_st.kprog_start = eff_kprog; // R13
    next_st.udata_start = eff_udata; // R13
    next_st.uprog_start = eff_uprog; // R13
    next_st.all_kernel  = (base_val[IDX_KPROG] == 32'h00000000)
                          && (base_val[IDX_UDATA] == 32'h00000000)
                          && (base_val[IDX_UPROG] == 32'h00000000); // R7
    next_st.fault       = fault_now;
    next_st.fault_any   = |fault_now;
  end

  // After reset every boundary sits at the RAM end, so the whole RAM
  // classifies as kernel data from the first cycle on.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st.ack         <= 1'b0;
      st.rdata       <= 32'h00000000;
      st.kprog_start <= RAM_SIZE; // R7
      st.udata_start <= RAM_SIZE; // R7
      st.uprog_start <= RAM_SIZE; // R7
      st.all_kernel  <= 1'b1; // R7
      st.fault       <= '0;
      st.fault_any   <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Classification uses the registered boundaries; a base write shows
  // in the answers two cycles after the write is taken.
  region_classifier u_classifier (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .query_valid_i  (query_valid_i),
    .query_addr_i   (query_addr_i),
    .kprog_start_i  (st.kprog_start),
    .udata_start_i  (st.udata_start),
    .uprog_start_i  (st.uprog_start),
    .ram_end_i      (RAM_SIZE),
    .region_valid_o (region_valid_o),
    .region_o       (region_o)
  );

  // Outputs come straight from the state register, except ram_end_o, which is the RAM_SIZE constant.
  assign wb_ack_o          = st.ack;
  assign wb_dat_o          = st.rdata;
  assign kprog_start_o     = st.kprog_start;
  assign udata_start_o     = st.udata_start;
  assign uprog_start_o     = st.uprog_start;
  assign ram_end_o         = RAM_SIZE;
  assign all_kernel_data_o = st.all_kernel;
  assign config_fault_o    = st.fault_any;

endmodule : data_ram_partition_regs
`default_nettype wire

//--- data_ram_partition_regs_assertions.sv
// Checker of the data RAM partition block ports.
// Assumes a master that holds each request until ack.
`timescale 1ns/1ps
`default_nettype none
`include "data_ram_partition_regs_regs.svh"

module data_ram_partition_checker
  import data_ram_partition_pkg::*;
#(
  parameter logic [31:0] RAM_SIZE = `RAM_SIZE_DEFAULT,
  parameter int          ADDR_W   = 8
) (
  // Clock, reset and bus.
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  // Query and boundaries.
  input wire logic              query_valid_i,
  input wire logic [31:0]       query_addr_i,
  input wire logic              region_valid_o,
  input var  region_e           region_o,
  input wire logic [31:0]       kprog_start_o,
  input wire logic [31:0]       udata_start_o,
  input wire logic [31:0]       uprog_start_o,
  input wire logic [31:0]       ram_end_o,
  input wire logic              all_kernel_data_o
);
  // Reference split of the RAM into its four regions.
  function automatic region_e want(input logic [31:0] a, k, u, p);
    if (a < k) return REGION_KERNEL_DATA;
    if (a < u) return REGION_KERNEL_PROG;
    if (a < p) return REGION_USER_DATA;
    if (a < RAM_SIZE) return REGION_USER_PROG;
    return REGION_OUTSIDE;
  endfunction : want

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Each region answer is held against the boundaries that stood at the query edge.
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_size_read: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == `OFS_RAM_SIZE |-> wb_dat_o == RAM_SIZE)
    else $error("size readout wrong");
  a_base_mask: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i <= `OFS_USER_PROG_BASE
    |-> (wb_dat_o & ~`BASE_WRITE_MASK) == 32'h0)
    else $error("base bits outside field set");
  a_start_grain: assert property (
    ((kprog_start_o | udata_start_o | uprog_start_o) & 32'h000003FF) == 32'h0)
    else $error("boundary not on 1 KB step");
  a_end_fixed: assert property (ram_end_o == RAM_SIZE)
    else $error("ram end not fixed");
  a_all_kernel: assert property (all_kernel_data_o |-> kprog_start_o == RAM_SIZE
    && udata_start_o == RAM_SIZE && uprog_start_o == RAM_SIZE)
    else $error("kernel data flag with region present");
  a_query_answer: assert property (query_valid_i |=> region_valid_o)
    else $error("query not answered");
  a_region_class: assert property (query_valid_i |=>
    region_o == want($past(query_addr_i), $past(kprog_start_o),
                        $past(udata_start_o), $past(uprog_start_o)))
    else $error("region answer wrong");
  a_reset_clear: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o
    && all_kernel_data_o && kprog_start_o == RAM_SIZE && udata_start_o == RAM_SIZE
    && uprog_start_o == RAM_SIZE)
    else $error("reset did not clear bases");

  // Main scenarios.
  c_write: cover property (wb_ack_o && wb_we_i);
  c_user_prog: cover property (region_valid_o && region_o == REGION_USER_PROG);
  c_outside: cover property (region_valid_o && region_o == REGION_OUTSIDE);
endmodule : data_ram_partition_checker

bind data_ram_partition_regs data_ram_partition_checker #(
  .RAM_SIZE(RAM_SIZE), .ADDR_W(ADDR_W)) chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .query_valid_i(query_valid_i), .query_addr_i(query_addr_i),
  .region_valid_o(region_valid_o), .region_o(region_o),
  .kprog_start_o(kprog_start_o), .udata_start_o(udata_start_o),
  .uprog_start_o(uprog_start_o), .ram_end_o(ram_end_o),
  .all_kernel_data_o(all_kernel_data_o));
`default_nettype wire

//--- ram_access_master.sv
// Model of a core asking which region a data RAM offset falls in.
// Assumes one answer the cycle after each taken query.
`timescale 1ns/1ps
`default_nettype none

module ram_access_master
  import data_ram_partition_pkg::*;
(
  // Clock and answer.
  input  wire logic   clk_i,
  input  wire logic   region_valid_i,
  input  var region_e region_i,
  // Query.
  output logic        query_valid_o,
  output logic [31:0] query_addr_o
);
  // Idle from time zero.
  initial begin
    query_valid_o = 1'b0;
    query_addr_o  = 32'h0;
  end

  // One query after gap idle cycles; the idle offset is inverted so it never looks valid.
  task automatic ask(input logic [31:0] a, input int gap, output region_e r, output logic v);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    query_valid_o <= 1'b1;
    query_addr_o  <= a;
    @(posedge clk_i);
    query_valid_o <= 1'b0;
    query_addr_o  <= ~a;
    @(posedge clk_i);
    v = region_valid_i;
    r = region_i;
  endtask : ask
endmodule : ram_access_master
`default_nettype wire

//--- data_ram_partition_regs_bench.sv
// Bench of the data RAM partition block over Wishbone and the query port.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
`include "data_ram_partition_regs_regs.svh"

module data_ram_partition_regs_bench
  import data_ram_partition_pkg::*;
();
  logic        clk_i, rst_i, cyc, stb, we, ack, qv, rv, akd, flt;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, qa, ks, us, ps, re;
  region_e     rg;
  int          bad_count, n_compared;
  logic [31:0] qa_t [8] = '{32'h0FFF, 32'h1000, 32'h1FFF, 32'h2000,
                            32'h3FFF, 32'h4000, 32'h7FFF, 32'h8000};
  region_e     qe_t [8] = '{REGION_KERNEL_DATA, REGION_KERNEL_PROG, REGION_KERNEL_PROG,
    REGION_USER_DATA, REGION_USER_DATA, REGION_USER_PROG, REGION_USER_PROG, REGION_OUTSIDE};

  data_ram_partition_regs dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .query_valid_i(qv), .query_addr_i(qa),
    .region_valid_o(rv), .region_o(rg), .kprog_start_o(ks), .udata_start_o(us),
    .uprog_start_o(ps), .ram_end_o(re), .all_kernel_data_o(akd), .config_fault_o(flt));
  ram_access_master cpu (.clk_i(clk_i), .region_valid_i(rv), .region_i(rg),
    .query_valid_o(qv), .query_addr_o(qa));

  // Free-running 50 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One classic cycle; the request stands until the edge that samples ack.
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) bad_count++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, 4'hF, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 4'h0, 32'h0, q);
    check(q, e);
  endtask : rd

  task automatic ask(input logic [31:0] a, input region_e e, input int gap);
    region_e r;
    logic    v;
    cpu.ask(a, gap, r, v);
    check(32'(v), 32'h1);
    check(32'(r), 32'(e));
  endtask : ask

  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // Whole run is about 120 cycles; this bound of 10000 cycles only catches a hang.
  initial begin
    #200000;
    bad_count++;
    results();
  end

  initial begin
    logic [31:0] d;
    rst_i = 1'b1;
    {cyc, stb, we, adr, sel, wdat} = '0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 3; i++) rd(8'(4 * i), 32'h0);
    rd(`OFS_RAM_SIZE, 32'h00008000);
    check(32'(akd), 32'h1);
    ask(32'h7FFF, REGION_KERNEL_DATA, 0);
    // Only the field at 15:10 keeps what is written.
    for (int i = 0; i < 3; i++) begin
      wr(8'(4 * i), 32'hFFFFFFFF);
      rd(8'(4 * i), `BASE_WRITE_MASK);
    end
    bus(1'b1, 8'h00, 4'hD, 32'h0, d);
    rd(8'h00, `BASE_WRITE_MASK);
    wr(`OFS_RAM_SIZE, 32'h0);
    rd(`OFS_RAM_SIZE, 32'h00008000);
    rd(8'h40, 32'h0);
    // Legal, ascending bases inside the RAM.
    wr(`OFS_KERNEL_PROG_BASE, 32'h000013FF);
    wr(`OFS_USER_DATA_BASE, 32'h2000);
    wr(`OFS_USER_PROG_BASE, 32'h4000);
    rd(`OFS_KERNEL_PROG_BASE, 32'h1000);
    check(ks, 32'h1000);
    check(us, 32'h2000);
    check(ps, 32'h4000);
    check(32'(akd), 32'h0);
    for (int i = 0; i < 8; i++) ask(qa_t[i], qe_t[i], i % 3);
    // Absent regions give way to the next one.
    wr(`OFS_KERNEL_PROG_BASE, 32'h0);
    wr(`OFS_USER_DATA_BASE, 32'h0);
    ask(32'h3FFF, REGION_KERNEL_DATA, 0);
    ask(32'h4000, REGION_USER_PROG, 0);
    wr(`OFS_USER_DATA_BASE, 32'h5000);
    // The fault output is registered from the stored bases, one edge after the ack edge.
    @(posedge clk_i);
    check(32'(flt), 32'h1);
    rd(`OFS_PART_STATUS, 32'h1 << `ST_UPROG_NOT_ABOVE);
    check(re, `RAM_SIZE_DEFAULT);
    // Reset in mid-run.
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`OFS_USER_PROG_BASE, 32'h0);
    rd(`OFS_USER_DATA_BASE, 32'h0);
    check(32'(akd), 32'h1);
    results();
  end
endmodule : data_ram_partition_regs_bench
`default_nettype wire
